//--- lcf_pkg.sv
// Package for the current-limit lock fault response block.
// Holds register offsets, field positions, reset values, timing tables and carrier types.
// Assumes a 50 MHz pclk and a 32-bit APB register bus.
package lcf_pkg;

   // Clock rate and millisecond tick
   localparam int unsigned LCF_CLK_HZ = 50_000_000;
   localparam int unsigned LCF_MS_PER_S = 1000;
   localparam int unsigned LCF_CYC_PER_MS = LCF_CLK_HZ / LCF_MS_PER_S;

   // Register byte offsets
   localparam logic [7:0] LCF_OFS_CONFIG = 8'h00;
   localparam logic [7:0] LCF_OFS_STATUS = 8'h04;
   localparam logic [7:0] LCF_OFS_MASK = 8'h08;
   localparam logic [7:0] LCF_OFS_STATE = 8'h0C;
   localparam logic [7:0] LCF_OFS_CTRL = 8'h10;

   // Configuration field positions (low bit of each field)
   localparam int LCF_POS_CBC_MODE = 23;
   localparam int LCF_POS_LOCK_THR = 19;
   localparam int LCF_POS_LOCK_MODE = 15;
   localparam int LCF_POS_FILT = 11;
   localparam int LCF_POS_CBC_RETRY = 8;
   localparam int LCF_POS_RETRY_SEL = 0;

   // Reset values
   localparam logic [31:0] LCF_CONFIG_RST = 32'h0000_0000;
   localparam logic [1:0] LCF_MASK_RST = 2'h0;
   localparam logic [1:0] LCF_STATUS_RST = 2'h0;

   // Status bit positions
   localparam int LCF_ST_LOCK = 0;
   localparam int LCF_ST_CBC = 1;

   // Lock response code boundaries
   localparam logic [3:0] LCF_MODE_RETRY_LO = 4'h4;
   localparam logic [3:0] LCF_MODE_REPORT = 4'h8;
   localparam logic [3:0] LCF_MODE_OFF_LO = 4'h9;
   // Cycle limit response codes that use the PWM retry count
   localparam logic [3:0] LCF_CBC_RETRY_FLT = 4'h4;
   localparam logic [3:0] LCF_CBC_RETRY_QUIET = 4'h5;

   // Deglitch filter times in ms, codes 0h..Fh
   localparam logic [16:0] LCF_FILT_MS [16] = '{
      17'd1, 17'd2, 17'd5, 17'd10, 17'd25, 17'd50, 17'd75, 17'd100,
      17'd250, 17'd500, 17'd1000, 17'd2500, 17'd5000, 17'd10000, 17'd25000, 17'd50000};

   // Lock retry delays in ms, codes 0h..7h
   localparam logic [16:0] LCF_RETRY_MS [8] = '{
      17'd100, 17'd500, 17'd1000, 17'd2000, 17'd3000, 17'd5000, 17'd7500, 17'd10000};

   // Output stage actions, in code order of the low two response bits
   typedef enum logic [1:0] {
      LCF_ACT_TRISTATE,
      LCF_ACT_RECIRC,
      LCF_ACT_HS_BRAKE,
      LCF_ACT_LS_BRAKE
   } lcf_act_t;

   // Decoded configuration fields
   typedef struct packed {
      logic [3:0] cycle_limit_response;
      logic [3:0] lock_threshold;
      logic [3:0] lock_response;
      logic [3:0] overcurrent_lock_filter_time;
      logic [2:0] cycle_limit_retry_count;
      logic [2:0] lock_retry_select;
   } lcf_cfg_t;

   // Commands to the power stage
   typedef struct packed {
      logic override;
      logic tristate;
      logic recirc;
      logic [2:0] hs_on;
      logic [2:0] ls_on;
   } lcf_drive_t;

endpackage : lcf_pkg

//--- lcf_ms_timer.sv
// Millisecond interval timer used for the lock filter and the retry delay.
// Assumes run is held high for the whole interval; dropping it restarts the count.
`timescale 1ns/10ps
module lcf_ms_timer
   import lcf_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = LCF_CYC_PER_MS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [16:0] target_ms,
   output logic done
);

   // Cycle prescaler within one millisecond
   logic [31:0] pre_r;
   // Whole milliseconds elapsed
   logic [16:0] ms_r;
   // One-cycle millisecond enable
   logic ms_tick;

   assign ms_tick = run && (pre_r == 32'(CYC_PER_MS - 1));
   // Level, held while the interval has fully elapsed
   assign done = run && (ms_r >= target_ms);

   // Prescaler restarts whenever run drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= 32'h0000_0000;
      end else if (!run || ms_tick) begin
         pre_r <= 32'h0000_0000;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   // Millisecond count saturates at the target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_r <= 17'h0_0000;
      end else if (!run) begin
         ms_r <= 17'h0_0000;
      end else if (ms_tick && !done) begin
         ms_r <= ms_r + 17'h0_0001;
      end
   end

endmodule : lcf_ms_timer

//--- lcf_lock_response.sv
// Current-limit lock fault response with APB registers and interrupt.
// Assumes sense_level is synchronous to pclk and expressed in 0.1 V steps.
// Assumes pwm_cycle_start and cbc_trip are one-cycle pulses from the PWM logic.
//
// Overview of operation
// - Codes 0h-3h latch fault, set chosen state
// - Brake states switch all high or low
// - Codes 4h-7h hold state for retry delay, then resume
// - Code 8h only reports the lock
// - Codes 9h and above disable lock detection
// - Filter code selects 1 ms to 50 s
// - Retry count field 0-7 gives 1-8 PWM cycle starts of hold
// - Retry select gives 100 to 10000 ms
// - Threshold 0.1-1.5 V, code 0 reserved
// - Cycle limit 4h/5h recovers after retry count
`timescale 1ns/10ps
module lcf_lock_response
   import lcf_pkg::*;
#(
   parameter int unsigned CYC_PER_MS = LCF_CYC_PER_MS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] sense_level,
   input wire logic pwm_cycle_start,
   input wire logic cbc_trip,
   output logic [2:0] hs_on,
   output logic [2:0] ls_on,
   output logic drive_tristate,
   output logic drive_recirc,
   output logic drive_override,
   output logic cbc_recirc,
   output logic fault_indicator_n,
   output logic irq
);

   // Lock handling states
   typedef enum logic [1:0] {
      LCF_IDLE,
      LCF_LATCHED,
      LCF_RETRY
   } lcf_state_t;

   // Register storage
   logic [31:0] config_r;
   logic [1:0] status_r;
   logic [1:0] mask_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   // Lock state and action held for the fault
   lcf_state_t state_r;
   lcf_act_t act_r;
   // Previous filter completion, for edge detect
   logic filt_done_q_r;
   // Cycle limit hold and remaining PWM cycles
   logic cbc_hold_r;
   logic cbc_flt_r;
   logic [2:0] cbc_left_r;
   // Registered power stage command
   lcf_drive_t drive_r;

   // Decoded fields and helper terms
   lcf_cfg_t cfg;
   logic wr_en;
   logic rd_setup;
   logic over_thr;
   logic lock_enabled;
   logic filt_run;
   logic filt_done;
   logic lock_event;
   logic retry_done;
   logic clear_fault;
   logic cbc_event;
   logic [1:0] status_set;
   lcf_drive_t drive_nxt;

   // Field decode of the configuration word
   always_comb begin
      cfg.cycle_limit_response = config_r[LCF_POS_CBC_MODE +: 4];
      cfg.lock_threshold = config_r[LCF_POS_LOCK_THR +: 4];
      cfg.lock_response = config_r[LCF_POS_LOCK_MODE +: 4];
      cfg.overcurrent_lock_filter_time = config_r[LCF_POS_FILT +: 4];
      cfg.cycle_limit_retry_count = config_r[LCF_POS_CBC_RETRY +: 3];
      cfg.lock_retry_select = config_r[LCF_POS_RETRY_SEL +: 3];
   end

   // APB phases: write at the access edge, read data prepared in setup
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   // Zero wait states once the access phase is reached
   assign pready = psel && penable;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // Read mux and unmapped address detection, evaluated in setup
   // Loading in setup keeps the read data steady through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_r <= 1'b0;
         if (paddr == LCF_OFS_CONFIG) begin
            prdata_r <= config_r;
         end else if (paddr == LCF_OFS_STATUS) begin
            prdata_r <= {30'h0000_0000, status_r};
         end else if (paddr == LCF_OFS_MASK) begin
            prdata_r <= {30'h0000_0000, mask_r};
         end else if (paddr == LCF_OFS_STATE) begin
            // Live block state for software
            prdata_r <= {24'h00_0000, cbc_left_r, cbc_hold_r, act_r, 2'(state_r)};
         end else if (paddr == LCF_OFS_CTRL) begin
            prdata_r <= 32'h0000_0000;
         end else begin
            // Unmapped: read zero and flag an error
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b1;
         end
         if (!rd_setup) begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // Configuration register, fully writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_r <= LCF_CONFIG_RST;
      end else if (wr_en && paddr == LCF_OFS_CONFIG) begin
         config_r <= pwdata;
      end
   end

   // Interrupt mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= LCF_MASK_RST;
      end else if (wr_en && paddr == LCF_OFS_MASK) begin
         mask_r <= pwdata[1:0];
      end
   end

   // Writing one to control bit 0 releases a latched lock fault
   assign clear_fault = wr_en && (paddr == LCF_OFS_CTRL) && pwdata[0];

   // Sticky status, write one to clear; a new event beats the clear
   // Events are one-cycle pulses, so one lost to a clear would never return
   assign status_set = {cbc_event, lock_event};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= LCF_STATUS_RST;
      end else begin
         if (wr_en && paddr == LCF_OFS_STATUS) begin
            status_r <= (status_r & ~pwdata[1:0]) | status_set;
         end else begin
            status_r <= status_r | status_set;
         end
      end
   end

   // Level interrupt while any unmasked status bit stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end

   // threshold compare, code 0 never trips
   assign over_thr = (cfg.lock_threshold != 4'h0) && (sense_level >= cfg.lock_threshold);

   // codes 9h and up disable detection
   assign lock_enabled = cfg.lock_response < LCF_MODE_OFF_LO;

   // filter runs only while continuously over
   assign filt_run = lock_enabled && over_thr && (state_r == LCF_IDLE);

   // The filter timer stops outside idle, which clears its count
   // deglitch time from the filter code
   lcf_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .run(filt_run),
      .target_ms(LCF_FILT_MS[cfg.overcurrent_lock_filter_time]),
      .done(filt_done)
   );

   // retry delay from the retry select code
   lcf_ms_timer #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_retry (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_r == LCF_RETRY),
      .target_ms(LCF_RETRY_MS[cfg.lock_retry_select]),
      .done(retry_done)
   );

   // One lock event per qualified overcurrent episode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_done_q_r <= 1'b0;
      end else begin
         filt_done_q_r <= filt_done;
      end
   end
   assign lock_event = filt_done && !filt_done_q_r;

   // Lock state machine
   // The action is captured at the event; later config writes leave it alone
   // Latch and retry both stop the filter, so it starts afresh back in idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= LCF_IDLE;
         act_r <= LCF_ACT_TRISTATE;
      end else begin
         case (state_r)
            LCF_IDLE: begin
               if (lock_event) begin
                  act_r <= lcf_act_t'(cfg.lock_response[1:0]);
                  if (cfg.lock_response < LCF_MODE_RETRY_LO) begin
                     state_r <= LCF_LATCHED;
                  end else if (cfg.lock_response < LCF_MODE_REPORT) begin
                     state_r <= LCF_RETRY;
                  end
                  // code 8h stays idle, status only
               end
            end
            LCF_LATCHED: begin
               // Held until software releases it
               if (clear_fault) begin
                  state_r <= LCF_IDLE;
               end
            end
            LCF_RETRY: begin
               if (retry_done) begin
                  state_r <= LCF_IDLE;
               end
            end
            default: begin
               state_r <= LCF_IDLE;
            end
         endcase
      end
   end

   // cycle limit retry applies to codes 4h and 5h
   assign cbc_event = cbc_trip && !cbc_hold_r &&
      ((cfg.cycle_limit_response == LCF_CBC_RETRY_FLT) ||
       (cfg.cycle_limit_response == LCF_CBC_RETRY_QUIET));

   // Trips during a hold are ignored so the count is never reloaded
   // count PWM cycles before the limiter retries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cbc_hold_r <= 1'b0;
         cbc_flt_r <= 1'b0;
         cbc_left_r <= 3'h0;
      end else if (cbc_event) begin
         cbc_hold_r <= 1'b1;
         cbc_flt_r <= cfg.cycle_limit_response == LCF_CBC_RETRY_FLT;
         cbc_left_r <= cfg.cycle_limit_retry_count;
      end else if (cbc_hold_r && pwm_cycle_start) begin
         // release when the count is used up
         if (cbc_left_r == 3'h0) begin
            cbc_hold_r <= 1'b0;
            cbc_flt_r <= 1'b0;
         end else begin
            cbc_left_r <= cbc_left_r - 3'h1;
         end
      end
   end
   assign cbc_recirc = cbc_hold_r;

   // Output stage command from the held action
   // Nothing is forced while idle; the PWM logic keeps control of the stage
   always_comb begin
      drive_nxt = '0;
      if (state_r != LCF_IDLE) begin
         drive_nxt.override = 1'b1;
         case (act_r)
            LCF_ACT_TRISTATE: begin
               drive_nxt.tristate = 1'b1;
            end
            LCF_ACT_RECIRC: begin
               drive_nxt.recirc = 1'b1;
            end
            LCF_ACT_HS_BRAKE: begin
               drive_nxt.hs_on = 3'h7;
            end
            LCF_ACT_LS_BRAKE: begin
               drive_nxt.ls_on = 3'h7;
            end
            default: begin
               drive_nxt.tristate = 1'b1;
            end
         endcase
      end
   end

   // Registered power stage command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_r <= '0;
      end else begin
         drive_r <= drive_nxt;
      end
   end
   assign drive_override = drive_r.override;
   assign drive_tristate = drive_r.tristate;
   assign drive_recirc = drive_r.recirc;
   assign hs_on = drive_r.hs_on;
   assign ls_on = drive_r.ls_on;

   // Registered so the pin never glitches on the state decode
   // fault pin active low while latched or cycle fault
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_indicator_n <= 1'b1;
      end else begin
         fault_indicator_n <= !((state_r == LCF_LATCHED) || cbc_flt_r);
      end
   end

endmodule : lcf_lock_response

//--- lcf_lock_props.sv
// Port checker for the lock fault response block.
// Assumes it is bound to lcf_lock_response and sees its ports only.
`timescale 1ns/10ps
module lcf_lock_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [3:0] sense_level,
   input wire logic pwm_cycle_start,
   input wire logic cbc_trip,
   input wire logic [2:0] hs_on,
   input wire logic [2:0] ls_on,
   input wire logic drive_tristate,
   input wire logic drive_recirc,
   input wire logic drive_override,
   input wire logic cbc_recirc
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Access phase of a bus transfer
   sequence s_access;
      psel && penable;
   endsequence
   // A trip pulse in one of the two cycles before
   sequence s_trip_seen;
      $past(cbc_trip) || $past(cbc_trip, 2);
   endsequence
   property p_ready;
      s_access |-> pready;
   endproperty
   property p_idle;
      !psel |-> !pready;
   endproperty
   property p_hs_brake;
      hs_on != 3'h0 |-> hs_on == 3'h7 && ls_on == 3'h0;
   endproperty
   property p_ls_brake;
      ls_on != 3'h0 |-> ls_on == 3'h7 && hs_on == 3'h0;
   endproperty
   property p_one_state;
      drive_tristate |-> !drive_recirc && hs_on == 3'h0 && ls_on == 3'h0;
   endproperty
   property p_action;
      (drive_tristate || drive_recirc || hs_on != 3'h0 || ls_on != 3'h0) |-> drive_override;
   endproperty
   property p_lock_cause;
      $rose(drive_override) |-> $past(sense_level, 4) != 4'h0;
   endproperty
   property p_cbc_set;
      $rose(cbc_recirc) |-> s_trip_seen;
   endproperty
   property p_cbc_release;
      $fell(cbc_recirc) |-> $past(pwm_cycle_start) || $past(pwm_cycle_start, 2);
   endproperty
   a_ready: assert property (p_ready) else $error("pready low in access phase");
   a_idle: assert property (p_idle) else $error("pready high without select");
   a_hs_brake: assert property (p_hs_brake) else $error("high side brake not all on");
   a_ls_brake: assert property (p_ls_brake) else $error("low side brake not all on");
   a_one_state: assert property (p_one_state) else $error("two stage states at once");
   a_action: assert property (p_action) else $error("stage action without override");
   a_lock_cause: assert property (p_lock_cause) else $error("lock without overcurrent");
   a_cbc_set: assert property (p_cbc_set) else $error("cycle hold without trip");
   a_cbc_release: assert property (p_cbc_release) else $error("cycle hold left off PWM start");
endmodule : lcf_lock_props

bind lcf_lock_response lcf_lock_props i_lcf_lock_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .sense_level(sense_level), .pwm_cycle_start(pwm_cycle_start),
   .cbc_trip(cbc_trip), .hs_on(hs_on), .ls_on(ls_on), .drive_tristate(drive_tristate),
   .drive_recirc(drive_recirc), .drive_override(drive_override), .cbc_recirc(cbc_recirc));

//--- lcf_stage_model.sv
// Power stage and current sense model facing the lock response block.
// Assumes the bench sets the current demand and asks for trips.
`timescale 1ns/10ps
module lcf_stage_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] demand,
   input wire logic trip_req,
   input wire logic drive_override,
   output logic [3:0] sense_level,
   output logic pwm_cycle_start,
   output logic cbc_trip
);
   logic [2:0] phase_r; // Position in the eight cycle PWM period
   // PWM period, trip pulse mid period, sensed current
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 3'h0;
         pwm_cycle_start <= 1'b0;
         cbc_trip <= 1'b0;
         sense_level <= 4'h0;
      end else begin
         phase_r <= phase_r + 3'h1;
         pwm_cycle_start <= phase_r == 3'h7;
         cbc_trip <= trip_req && phase_r == 3'h3;
         // A stage held off by the block carries no current
         sense_level <= drive_override ? 4'h0 : demand;
      end
   end
endmodule : lcf_stage_model

//--- lcf_lock_response_test.sv
// Self-checking bench for the lock fault response block.
// Assumes a shortened millisecond of 5 cycles and the stage model.
`timescale 1ns/10ps
module lcf_lock_response_test;
   import lcf_pkg::*;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, rerr, trip_req, flt;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] sense_level, demand;
   logic pwm_cycle_start, cbc_trip, drive_tristate, drive_recirc, drive_override;
   logic cbc_recirc, fault_indicator_n, irq;
   logic [2:0] hs_on, ls_on;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 32'hb0ed;
   int m, n, k, i;
   int filt_ms[4] = '{1, 2, 5, 10}; // First filter times in ms
   always #10 pclk = ~pclk;
   lcf_lock_response #(.CYC_PER_MS(5)) i_lcf_lock_response (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sense_level(sense_level), .pwm_cycle_start(pwm_cycle_start), .cbc_trip(cbc_trip),
      .hs_on(hs_on), .ls_on(ls_on), .drive_tristate(drive_tristate), .drive_recirc(drive_recirc),
      .drive_override(drive_override), .cbc_recirc(cbc_recirc), .fault_indicator_n(fault_indicator_n),
      .irq(irq));
   lcf_stage_model i_lcf_stage_model (.pclk(pclk), .presetn(presetn), .demand(demand), .trip_req(trip_req),
      .drive_override(drive_override), .sense_level(sense_level), .pwm_cycle_start(pwm_cycle_start),
      .cbc_trip(cbc_trip));
   // Verdict and end of run
   task close_out;
      $display("Checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Expected stage state {override, tristate, recirc, hs, ls}
   function logic [8:0] exp_out(int code);
      if (code > 7) return 9'h0;
      return {1'b1, code % 4 == 0, code % 4 == 1, (code % 4 == 2) ? 3'h7 : 3'h0, (code % 4 == 3) ? 3'h7 : 3'h0};
   endfunction : exp_out
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         close_out;
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, demand, trip_req, presetn} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, LCF_OFS_CONFIG, 0);
      chk("config reset", rd, LCF_CONFIG_RST);
      apb(0, 8'h40, 0);
      chk("unmapped", {rd[30:0], rerr}, 1);
      k = $random(seed);
      apb(1, LCF_OFS_CONFIG, k);
      apb(0, LCF_OFS_CONFIG, 0);
      chk("config rw", rd, k);
      // Lock response codes 0h to 9h, threshold 0.1 V, filter 2 ms
      for (m = 0; m < 10; m++) begin
         apb(1, LCF_OFS_MASK, m % 2);
         apb(1, LCF_OFS_CONFIG, (m << LCF_POS_LOCK_MODE) | (1 << LCF_POS_FILT) | (1 << LCF_POS_LOCK_THR));
         demand <= 4'h1 + 4'($unsigned($random(seed)) % 15);
         repeat (6) @(posedge pclk);
         demand <= 4'h0;
         apb(0, LCF_OFS_STATUS, 0);
         chk("short burst", rd[0], 0);
         demand <= 4'h3;
         repeat (40) @(posedge pclk);
         chk("stage", {drive_override, drive_tristate, drive_recirc, hs_on, ls_on}, exp_out(m));
         if (m < 4 || m > 7) chk("fault pin", fault_indicator_n, m > 3);
         chk("irq", irq, m % 2 == 1 && m < 9);
         apb(0, LCF_OFS_STATUS, 0);
         chk("lock status", rd[0], m < 9);
         demand <= 4'h0;
         if (m > 3 && m < 8) begin
            repeat (420) @(posedge pclk);
            chk("held", drive_override, 1);
            repeat (120) @(posedge pclk);
            chk("resumed", drive_override, 0);
         end
         if (m < 4) apb(1, LCF_OFS_CTRL, 1);
         apb(1, LCF_OFS_STATUS, 3);
         repeat (3) @(posedge pclk);
         chk("cleared", {irq, drive_override}, 0);
      end
      // First filter codes: quiet just before the time, locked just after
      for (k = 0; k < 4; k++) begin
         apb(1, LCF_OFS_CONFIG, (1 << LCF_POS_LOCK_MODE) | (k << LCF_POS_FILT) | (15 << LCF_POS_LOCK_THR));
         demand <= 4'hf;
         repeat (filt_ms[k] * 5 - 2) @(posedge pclk);
         chk("before filter", drive_override, 0);
         repeat (12) @(posedge pclk);
         chk("after filter", drive_recirc, 1);
         demand <= 4'h0;
         apb(1, LCF_OFS_CTRL, 1);
         apb(1, LCF_OFS_STATUS, 3);
      end
      // Cycle limit responses 4h to 6h with a random retry count
      for (m = 4; m < 7; m++) begin
         n = $unsigned($random(seed)) % 8;
         apb(1, LCF_OFS_CONFIG, (m << LCF_POS_CBC_MODE) | (n << LCF_POS_CBC_RETRY) | (9 << LCF_POS_LOCK_MODE));
         k = 0;
         flt = 1'b0;
         for (i = 0; i < 90; i++) begin
            trip_req <= i < 8;
            // Look at settled values halfway through the cycle
            @(negedge pclk);
            if (cbc_recirc === 1'b1 && pwm_cycle_start === 1'b1) k++;
            if (cbc_recirc === 1'b1 && fault_indicator_n === 1'b0) flt = 1'b1;
            @(posedge pclk);
         end
         chk("cbc pwm count", k, (m == 6) ? 0 : n + 1);
         chk("cbc fault", flt, m == 4);
         apb(0, LCF_OFS_STATUS, 0);
         chk("cbc status", rd[1], m != 6);
         apb(1, LCF_OFS_STATUS, 3);
      end
      close_out;
   end
endmodule : lcf_lock_response_test
